//--- design/dmt_timer.sv
// Dual 16-bit compare match timer with APB register slave
// ---------------------------------------------------------------
// Operation
// ---------------------------------------------------------------
module dmt_timer
  import dmt_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [1:0]  matchIrq,
  output logic      [1:0]  xferReq,
  input  wire logic [1:0]  xferDone,
  input  wire logic [1:0]  xferDisableSel
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [PRESC_W-1:0] prescReg;
  logic [1:0]         runReg;
  logic [15:0]        cntReg   [2];
  logic [15:0]        perReg   [2];
  logic [1:0]         selReg   [2];
  logic [1:0]         ieReg;
  logic [1:0]         flagReg;
  logic [1:0]         readOneReg;
  logic [31:0]        prdataReg;
  logic               preadyReg;
  logic               pslverrReg;
  logic [1:0]         matchIrqReg;
  logic [1:0]         xferReqReg;

  logic        setupPh;
  logic        accessDone;
  logic        wrDone;
  logic        rdDone;
  logic        mapped;
  logic [31:0] rdValue;
  logic [1:0]  tick;
  logic [1:0]  matchEv;
  logic [1:0]  incEv;
  logic [1:0]  cntWr;
  logic [1:0]  perWr;
  logic [1:0]  ctrlWr;
  logic [1:0]  ctrlRd;
  logic [1:0]  swClr;
  logic [1:0]  xferClr;
  logic [1:0]  irqNext;

  assign prdata   = prdataReg;
  assign pready   = preadyReg;
  assign pslverr  = pslverrReg;
  assign matchIrq = matchIrqReg;
  assign xferReq  = xferReqReg;

  // ---------------------------------------------------------------
  // APB slave, one wait-free access phase
  // ---------------------------------------------------------------
  assign setupPh    = psel && !penable && !preadyReg;
  assign accessDone = psel && penable && preadyReg;
  assign wrDone     = accessDone && pwrite && !pslverrReg;
  assign rdDone     = accessDone && !pwrite && !pslverrReg;

  function automatic logic [15:0] mergeBytes(input logic [15:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  strb);
    mergeBytes = {strb[1] ? wd[15:8] : old[15:8], strb[0] ? wd[7:0] : old[7:0]};
  endfunction

  always_comb begin
    mapped  = 1'b1;
    rdValue = 32'h0000_0000;
    case (paddr)
      OFS_RUN:   rdValue = {30'h0000_0000, runReg};
      OFS_CTRL0: rdValue = {24'h00_0000, flagReg[0], ieReg[0], 4'h0, selReg[0]};
      OFS_CNT0:  rdValue = {16'h0000, cntReg[0]};
      OFS_PER0:  rdValue = {16'h0000, perReg[0]};
      OFS_CTRL1: rdValue = {24'h00_0000, flagReg[1], ieReg[1], 4'h0, selReg[1]};
      OFS_CNT1:  rdValue = {16'h0000, cntReg[1]};
      OFS_PER1:  rdValue = {16'h0000, perReg[1]};
      default:   mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      preadyReg  <= 1'b0;
      pslverrReg <= 1'b0;
      prdataReg  <= 32'h0000_0000;
    end else if (setupPh) begin
      preadyReg  <= 1'b1;
      pslverrReg <= !mapped;
      prdataReg  <= pwrite ? 32'h0000_0000 : rdValue;
    end else begin
      preadyReg  <= 1'b0;
      pslverrReg <= 1'b0;
    end
  end

  // Only bits 1:0 are stored; upper reserved bits drop away
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      runReg <= RST_RUN;
    end else if (wrDone && paddr == OFS_RUN && pstrb[0]) begin
      runReg <= pwdata[BIT_RUN1:BIT_RUN0];
    end
  end

  // ---------------------------------------------------------------
  // Prescaler
  // ---------------------------------------------------------------
  // Free-running so that both channels share one divider and stay in phase
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prescReg <= '0;
    end else begin
      prescReg <= prescReg + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Channels
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : gCh
    localparam logic [7:0] OFS_C = (g == 0) ? OFS_CTRL0 : OFS_CTRL1;
    localparam logic [7:0] OFS_N = (g == 0) ? OFS_CNT0  : OFS_CNT1;
    localparam logic [7:0] OFS_P = (g == 0) ? OFS_PER0  : OFS_PER1;

    always_comb begin
      case (selReg[g])
        2'h0:    tick[g] = (prescReg & MASK0) == MASK0;
        2'h1:    tick[g] = (prescReg & MASK1) == MASK1;
        2'h2:    tick[g] = (prescReg & MASK2) == MASK2;
        default: tick[g] = (prescReg & MASK3) == MASK3;
      endcase
    end

    // Match is taken on the tick that would leave the matching value
    assign matchEv[g] = runReg[g] && tick[g] && cntReg[g] == perReg[g];
    assign incEv[g]   = runReg[g] && tick[g] && cntReg[g] != perReg[g];
    assign cntWr[g]   = wrDone && paddr == OFS_N;
    assign perWr[g]   = wrDone && paddr == OFS_P;
    assign ctrlWr[g]  = wrDone && paddr == OFS_C;
    assign ctrlRd[g]  = rdDone && paddr == OFS_C;
    assign swClr[g]   = ctrlWr[g] && pstrb[0] && !pwdata[BIT_FLAG] && readOneReg[g];
    assign xferClr[g] = xferDone[g] && !xferDisableSel[g];

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        cntReg[g] <= RST_CNT;
      end else if (matchEv[g]) begin
        cntReg[g] <= RST_CNT;
      end else if (cntWr[g]) begin
        cntReg[g] <= mergeBytes(cntReg[g], pwdata, pstrb);
      end else if (incEv[g]) begin
        cntReg[g] <= cntReg[g] + 16'h0001;
      end
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        perReg[g] <= RST_PER;
      end else if (perWr[g]) begin
        perReg[g] <= mergeBytes(perReg[g], pwdata, pstrb);
      end
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        selReg[g] <= RST_SEL;
        ieReg[g]  <= 1'b0;
      end else if (ctrlWr[g] && pstrb[0]) begin
        selReg[g] <= pwdata[BIT_SEL_HI:BIT_SEL_LO];
        ieReg[g]  <= pwdata[BIT_IE];
      end
    end

    // A read that saw the flag high arms the software clear
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        readOneReg[g] <= 1'b0;
      end else if (ctrlWr[g]) begin
        readOneReg[g] <= 1'b0;
      end else if (ctrlRd[g] && prdataReg[BIT_FLAG]) begin
        readOneReg[g] <= 1'b1;
      end
    end

    // Set wins over any clear arriving in the same cycle
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        flagReg[g] <= 1'b0;
      end else if (matchEv[g]) begin
        flagReg[g] <= 1'b1;
      end else if (swClr[g] || xferClr[g]) begin
        flagReg[g] <= 1'b0;
      end
    end

    assign irqNext[g] = flagReg[g] && ieReg[g];

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        matchIrqReg[g] <= 1'b0;
      end else begin
        matchIrqReg[g] <= irqNext[g];
      end
    end

    // ---------------------------------------------------------------
    // Channel checks
    // ---------------------------------------------------------------
    sequence sMatch;
      matchEv[g] && !cntWr[g];
    endsequence

    sequence sCleared;
      cntReg[g] == RST_CNT && flagReg[g];
    endsequence

    property pMatchClear;
      @(posedge clk) disable iff (reset) sMatch |=> sCleared;
    endproperty

    AST_MATCH_CLEAR: assert property (pMatchClear)
      else $error("match did not clear counter and set flag");

    AST_WRITE_LOSES_TO_MATCH: assert property (@(posedge clk) disable iff (reset)
      matchEv[g] && cntWr[g] |=> cntReg[g] == RST_CNT)
      else $error("counter write overrode match clear");

    AST_INCREMENT: assert property (@(posedge clk) disable iff (reset)
      incEv[g] && !cntWr[g] |=> cntReg[g] == $past(cntReg[g]) + 16'h0001)
      else $error("counter did not increment on tick");

    AST_WRITE_BEATS_INC: assert property (@(posedge clk) disable iff (reset)
      incEv[g] && cntWr[g] && pstrb[1:0] == 2'h3 |=> cntReg[g] == $past(pwdata[15:0]))
      else $error("increment overrode counter write");

    AST_HALT_HOLDS: assert property (@(posedge clk) disable iff (reset)
      !runReg[g] && !cntWr[g] |=> $stable(cntReg[g]))
      else $error("halted counter changed");

    AST_FLAG_ONLY_AT_TICK: assert property (@(posedge clk) disable iff (reset)
      $rose(flagReg[g]) |-> $past(tick[g]) && $past(cntReg[g] == perReg[g]))
      else $error("flag set away from a matching tick");

    AST_CLEAR_NEEDS_READ: assert property (@(posedge clk) disable iff (reset)
      $fell(flagReg[g]) |-> $past(xferClr[g]) || $past(readOneReg[g]))
      else $error("flag cleared without prior read of one");

    AST_XFER_CLEAR: assert property (@(posedge clk) disable iff (reset)
      xferClr[g] && !matchEv[g] |=> !flagReg[g])
      else $error("transfer did not clear flag");

    AST_IRQ_FOLLOWS: assert property (@(posedge clk) disable iff (reset)
      flagReg[g] && ieReg[g] |=> matchIrq[g])
      else $error("interrupt not raised for enabled flag");

    AST_IRQ_QUIET: assert property (@(posedge clk) disable iff (reset)
      !(flagReg[g] && ieReg[g]) |=> !matchIrq[g])
      else $error("interrupt raised without enabled flag");

    // Every tap mask covers the low three bits, so ticks stay at least eight apart
    sequence sTickQuiet;
      (!tick[g]) [*7];
    endsequence

    AST_TICK_SPACING: assert property (@(posedge clk) disable iff (reset)
      tick[g] |=> sTickQuiet)
      else $error("prescaler tick too long or too soon");

    AST_TICK_DIV8: assert property (@(posedge clk) disable iff (reset)
      tick[g] && selReg[g] == 2'h0 ##1 (selReg[g] == 2'h0) [*8] |-> tick[g])
      else $error("divide by eight tap missed its tick");

    AST_FLAG_SET_SOURCE: assert property (@(posedge clk) disable iff (reset)
      $rose(flagReg[g]) |-> $past(matchEv[g]))
      else $error("flag set by something other than a match");

    AST_WRITE_ONE_IGNORED: assert property (@(posedge clk) disable iff (reset)
      ctrlWr[g] && pstrb[0] && pwdata[BIT_FLAG] && !matchEv[g] && !xferClr[g]
      |=> $stable(flagReg[g]))
      else $error("writing one changed the flag");

    AST_ARMED_CLEAR: assert property (@(posedge clk) disable iff (reset)
      swClr[g] && !matchEv[g] |=> !flagReg[g])
      else $error("armed zero write did not clear flag");

    sequence sQuietAfterMatch;
      sMatch ##1 (!cntWr[g]) [*7];
    endsequence

    AST_RESTART: assert property (@(posedge clk) disable iff (reset)
      sQuietAfterMatch ##1 (incEv[g] && !cntWr[g]) |=> cntReg[g] == 16'h0001)
      else $error("counter did not restart from zero after match");

    AST_PERIOD_WRITE: assert property (@(posedge clk) disable iff (reset)
      perWr[g] && pstrb[1:0] == 2'h3 |=> perReg[g] == $past(pwdata[15:0]))
      else $error("period write not stored");

    AST_RESET_VALUES: assert property (@(posedge clk) disable iff (reset)
      $fell(reset) |-> cntReg[g] == RST_CNT && perReg[g] == RST_PER)
      else $error("counter or period left reset with wrong value");
  end

  // ---------------------------------------------------------------
  // Transfer request, fixed priority
  // ---------------------------------------------------------------
  // Channel 0 wins ties; channel 1 waits until channel 0 is served
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      xferReqReg <= 2'h0;
    end else begin
      xferReqReg[0] <= irqNext[0];
      xferReqReg[1] <= irqNext[1] && !irqNext[0];
    end
  end

  AST_XFER_PRIORITY: assert property (@(posedge clk) disable iff (reset)
    irqNext[0] |=> xferReq[0] && !xferReq[1])
    else $error("channel 1 served ahead of channel 0");

  AST_RUN_RESERVED: assert property (@(posedge clk) disable iff (reset)
    setupPh && !pwrite && paddr == OFS_RUN |=> prdata[31:2] == 30'h0000_0000)
    else $error("reserved run bits read nonzero");

  AST_CTRL_RESERVED: assert property (@(posedge clk) disable iff (reset)
    setupPh && !pwrite && paddr == OFS_CTRL0 |=> prdata[31:8] == 24'h00_0000
      && prdata[5:2] == 4'h0 && prdata[BIT_FLAG] == $past(flagReg[0]))
    else $error("control register read layout wrong");

  // ---------------------------------------------------------------
  // Write path and second channel checks
  // ---------------------------------------------------------------
  AST_CTRL1_RESERVED: assert property (@(posedge clk) disable iff (reset)
    setupPh && !pwrite && paddr == OFS_CTRL1 |=> prdata[31:8] == 24'h00_0000
      && prdata[5:2] == 4'h0 && prdata[BIT_FLAG] == $past(flagReg[1]))
    else $error("control register read layout wrong");

  AST_RUN_WRITE: assert property (@(posedge clk) disable iff (reset)
    wrDone && paddr == OFS_RUN && pstrb[0] |=> runReg == $past(pwdata[1:0]))
    else $error("run bits not taken from write");

  AST_XFER_SECOND: assert property (@(posedge clk) disable iff (reset)
    irqNext[1] && !irqNext[0] |=> xferReq[1])
    else $error("channel 1 not served while channel 0 idle");

endmodule

//--- pkg/dmt_pkg.sv
// Constants shared by the dual compare match timer
package dmt_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_RUN   = 8'h00;
  localparam logic [7:0] OFS_CTRL0 = 8'h04;
  localparam logic [7:0] OFS_CNT0  = 8'h08;
  localparam logic [7:0] OFS_PER0  = 8'h0C;
  localparam logic [7:0] OFS_CTRL1 = 8'h10;
  localparam logic [7:0] OFS_CNT1  = 8'h14;
  localparam logic [7:0] OFS_PER1  = 8'h18;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_RUN0     = 0;
  localparam int BIT_RUN1     = 1;
  localparam int BIT_FLAG     = 7;
  localparam int BIT_IE       = 6;
  localparam int BIT_SEL_LO   = 0;
  localparam int BIT_SEL_HI   = 1;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_CNT = 16'h0000;
  localparam logic [15:0] RST_PER = 16'hFFFF;
  localparam logic [1:0]  RST_RUN = 2'h0;
  localparam logic [1:0]  RST_SEL = 2'h0;
  // ---------------------------------------------------------------
  // Prescaler taps, clock cycles per tick
  // ---------------------------------------------------------------
  localparam int DIV_SEL0 = 8;
  localparam int DIV_SEL1 = 32;
  localparam int DIV_SEL2 = 128;
  localparam int DIV_SEL3 = 512;
  localparam int PRESC_W  = $clog2(DIV_SEL3);
  localparam logic [PRESC_W-1:0] MASK0 = PRESC_W'(DIV_SEL0 - 1);
  localparam logic [PRESC_W-1:0] MASK1 = PRESC_W'(DIV_SEL1 - 1);
  localparam logic [PRESC_W-1:0] MASK2 = PRESC_W'(DIV_SEL2 - 1);
  localparam logic [PRESC_W-1:0] MASK3 = PRESC_W'(DIV_SEL3 - 1);
endpackage

//--- tb/dmt_timer_tb_top.sv
// Self-checking testbench for the dual compare match timer
module dmt_timer_tb_top
  import dmt_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // Signals and tables
  // ---------------------------------------------------------------
  logic        clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  matchIrq;
  logic [1:0]  xferReq;
  logic [1:0]  xferDone;
  logic [1:0]  xferDisableSel;
  logic [31:0] seed = 32'h0000334B;
  logic [32:0] expQ[$];
  int          badCount = 0;
  int          nTests = 0;
  localparam logic [7:0]  OFFS[7] = '{OFS_RUN, OFS_CTRL0, OFS_CNT0, OFS_PER0,
                                      OFS_CTRL1, OFS_CNT1, OFS_PER1};
  localparam logic [15:0] RSTV[7] = '{16'h0000, 16'h0000, RST_CNT, RST_PER,
                                      16'h0000, RST_CNT, RST_PER};
  localparam int          DIVS[4] = '{DIV_SEL0, DIV_SEL1, DIV_SEL2, DIV_SEL3};

  dmt_timer dmt_timer_i (
    .clk            (clk),
    .reset          (reset),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .pstrb          (pstrb),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .matchIrq       (matchIrq),
    .xferReq        (xferReq),
    .xferDone       (xferDone),
    .xferDisableSel (xferDisableSel)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    nTests++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Request held from setup until pready is sampled high; upper data bits random
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d,
                     input logic [32:0] e);
    logic [31:0] r;
    int          n;
    r = xs();
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {r[31:16], d};
    pstrb   <= 4'hF;
    if (!wr) expQ.push_back(e);
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) badCount++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] d);
    apb(1'b0, a, 16'h0000, {17'h00000, d});
  endtask

  task automatic wait_irq(input int ch, output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (matchIrq[ch] !== 1'b1 && n < 5000);
    if (matchIrq[ch] !== 1'b1) badCount++;
  endtask

  // Five edges from call to return, the clear lands well inside that
  task automatic pulse(input int ch, input logic dis);
    @(posedge clk);
    xferDone[ch]       <= 1'b1;
    xferDisableSel[ch] <= dis;
    @(posedge clk);
    xferDone <= 2'b00;
    repeat (3) @(posedge clk);
  endtask
  // ---------------------------------------------------------------
  // Read monitor: oldest note against each completed read
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0) begin
      chk({pslverr, prdata}, expQ.pop_front());
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    badCount++;
    tally_and_finish();
  end
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int          n;
    int          p;
    logic [15:0] v;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
    xferDone = 2'b00;
    xferDisableSel = 2'b00;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rd(OFFS[i], RSTV[i]);
    end
    // Unmapped place refuses and reads zero
    wr(8'h1C, 16'(xs()));
    apb(1'b0, 8'h1C, 16'h0000, {1'b1, 32'h0000_0000});
    wr(OFS_CTRL0, 16'hFFFF);
    rd(OFS_CTRL0, 16'h0043);
    wr(OFS_RUN, 16'hFFFC);
    rd(OFS_RUN, 16'h0000);
    rd(OFS_CTRL1, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      p = 1 + int'(xs() % 3);
      wr(OFS_RUN, 16'h0000);
      wr(OFS_CNT0, 16'h0000);
      wr(OFS_PER0, 16'(p));
      wr(OFS_CTRL0, 16'h0040 | 16'(s));
      wr(OFS_RUN, 16'h0001);
      pulse(0, 1'b0);
      wait_irq(0, n);
      pulse(0, 1'b0);
      wait_irq(0, n);
      chk(33'(n + 5), 33'((p + 1) * DIVS[s]));
    end
    // Halted counter keeps a written value
    v = 16'(xs());
    wr(OFS_RUN, 16'h0000);
    wr(OFS_CNT0, v);
    repeat (600) @(posedge clk);
    rd(OFS_CNT0, v);
    // Counter writes every three cycles sweep all eight prescaler phases
    wr(OFS_CTRL0, 16'h0000);
    wr(OFS_PER0, 16'h0005);
    wr(OFS_RUN, 16'h0001);
    for (int k = 0; k < 9; k++) begin
      wr(OFS_CNT0, 16'h0005);
    end
    wr(OFS_PER0, 16'hFFFF);
    for (int k = 0; k < 9; k++) begin
      wr(OFS_CNT0, v);
    end
    rd(OFS_PER0, 16'hFFFF);
    wr(OFS_RUN, 16'h0000);
    wr(OFS_CNT0, 16'h0000);
    wr(OFS_PER0, 16'h0001);
    wr(OFS_CTRL0, 16'h0040);
    wr(OFS_CNT1, 16'h0000);
    wr(OFS_PER1, 16'h0002);
    wr(OFS_CTRL1, 16'h0040);
    wr(OFS_RUN, 16'h0003);
    repeat (60) @(posedge clk);
    wr(OFS_RUN, 16'h0000);
    repeat (3) @(posedge clk);
    chk(33'({xferReq, matchIrq}), 33'h7);
    pulse(0, 1'b1);
    chk(33'({xferReq, matchIrq}), 33'h7);
    pulse(0, 1'b0);
    chk(33'({xferReq, matchIrq}), 33'hA);
    // A zero write clears the flag only after it was read as one
    wr(OFS_CTRL1, 16'h0040);
    rd(OFS_CTRL1, 16'h00C0);
    wr(OFS_CTRL1, 16'h00C0);
    rd(OFS_CTRL1, 16'h00C0);
    wr(OFS_CTRL1, 16'h0040);
    rd(OFS_CTRL1, 16'h0040);
    repeat (3) @(posedge clk);
    chk(33'({xferReq, matchIrq}), 33'h0);
    repeat (5) @(posedge clk);
    tally_and_finish();
  end
endmodule
